// ---- shared/aabe_cfg.svh ----
// Purpose: Shared constants for the accumulator add, mask and bit-operation datapath.
// Assumes: Included by the package and the design modules by its bare name.
// Notes:   Only definitions live here.
`ifndef AABE_CFG_SVH
`define AABE_CFG_SVH

// ==========================================================================
// Register file and bus map
// ==========================================================================
`define AABE_FILE_COUNT   128
`define AABE_ACC_ADDR     8'h80
`define AABE_STAT_ADDR    8'h81
`define AABE_FILE_SEL_BIT 7
`define AABE_PORT_FILE    7'h06
`define AABE_BYTE_RST     8'h00
`define AABE_STAT_PAD     5'h00

// ==========================================================================
// Status bit positions and destination select codes
// ==========================================================================
`define AABE_C_BIT        0
`define AABE_DC_BIT       1
`define AABE_Z_BIT        2
`define AABE_NIB_MSB      3
`define AABE_BYTE_MSB     7
`define AABE_DEST_ACC     1'b0
`define AABE_DEST_FILE    1'b1

`endif

// ---- shared/aabe_pkg.sv ----
// Purpose: Types and the bit-mask decoder shared by the datapath modules.
// Assumes: aabe_cfg.svh supplies the numeric constants.
// Notes:   Nothing here is imported; users write aabe_pkg::name.
`include "aabe_cfg.svh"

package aabe_pkg;

  // ========================================================================
  // Instruction and unit operation kinds
  // ========================================================================
  typedef enum logic [2:0] {
    op_none,
    immediate_sum_op,
    register_sum_op,
    immediate_mask_op,
    register_mask_op,
    single_position_clear_op,
    single_position_set_op,
    test_then_skip_if_zero_op
  } aabe_op_t;

  typedef enum logic [1:0] {
    ALU_ADD,
    ALU_AND,
    ALU_CLR,
    ALU_SET
  } aabe_alu_t;

  typedef enum logic {
    PH_RUN,
    PH_DISCARD
  } aabe_phase_t;

  // ========================================================================
  // Core state
  // ========================================================================
  typedef struct packed {
    logic [`AABE_FILE_COUNT-1:0][7:0] files;
    logic [7:0]                       acc;
    logic                             flag_carry;
    logic                             nibble_overflow_bit;
    logic                             flag_zero;
    logic [7:0]                       rdata;
    aabe_phase_t                      phase;
  } aabe_state_t;

  // One-hot mask of the selected bit position.
  function automatic logic [7:0] aabe_bit_mask(input logic [2:0] idx);
    logic [7:0] m;
    m = 8'h01;
    aabe_bit_mask = m << idx;
  endfunction : aabe_bit_mask

endpackage : aabe_pkg

// ---- shared/aabe_alu_if.sv ----
// Purpose: Operand and result bundle between the core and its arithmetic unit.
// Assumes: Purely combinational traffic; no clock in the bundle.
// Notes:   The core drives operands, the unit returns result and flags.
`timescale 1ns/1ps
`default_nettype none

interface aabe_alu_if;
  logic [7:0]          a;
  logic [7:0]          b;
  aabe_pkg::aabe_alu_t kind;
  logic [2:0]          bit_idx;
  logic [7:0]          y;
  logic                carry;
  logic                nib_carry;
  logic                zero;

  modport core (output a, output b, output kind, output bit_idx,
                input y, input carry, input nib_carry, input zero);
  modport unit (input a, input b, input kind, input bit_idx,
                output y, output carry, output nib_carry, output zero);
endinterface : aabe_alu_if

`default_nettype wire

// ---- hw/aabe_alu.sv ----
// Purpose: Combinational add, AND and single-bit clear/set unit.
// Assumes: Operands stable within the cycle.
// Notes:   Flags are computed for every kind; the core decides which to keep.
`timescale 1ns/1ps
`default_nettype none
`include "aabe_cfg.svh"

module aabe_alu (
  aabe_alu_if.unit u
);

  logic [8:0] sum9;
  logic [4:0] nib5;

  // ========================================================================
  // Datapath
  // ========================================================================
  always_comb
  begin
    sum9 = {1'b0, u.a} + {1'b0, u.b};
    nib5 = {1'b0, u.a[`AABE_NIB_MSB:0]} + {1'b0, u.b[`AABE_NIB_MSB:0]};
    case (u.kind)
      aabe_pkg::ALU_ADD: u.y = sum9[`AABE_BYTE_MSB:0];
      aabe_pkg::ALU_AND: u.y = u.a & u.b;
      aabe_pkg::ALU_CLR: u.y = u.a & ~aabe_pkg::aabe_bit_mask(u.bit_idx);
      aabe_pkg::ALU_SET: u.y = u.a | aabe_pkg::aabe_bit_mask(u.bit_idx);
      default:           u.y = `AABE_BYTE_RST;
    endcase
    u.carry     = sum9[`AABE_BYTE_MSB+1];
    u.nib_carry = nib5[`AABE_NIB_MSB+1];
    u.zero      = (u.y == `AABE_BYTE_RST);
  end

endmodule : aabe_alu

`default_nettype wire

// ---- hw/aabe_exec.sv ----
// Purpose: Executes add, AND, bit clear/set and bit-test-skip on an accumulator and register file.
// Assumes: One instruction per clock, presented with instr_valid; synchronous inputs.
// Notes:   The register file and the port latch live here in flip-flops.
//
// What this block does
// - Immediate add puts accumulator plus immediate in accumulator, updating carry, nibble, zero.
// - Register add sums accumulator and addressed register, updating carry, nibble and zero.
// - Destination 0 sends register add and AND results to accumulator, 1 back to register.
// - Immediate AND puts accumulator AND immediate in accumulator, only zero flag changes.
// - Register AND sends accumulator AND register to destination, only zero flag changes.
// - Bit clear forces the indexed bit of the register low, flags untouched.
// - Bit set forces the indexed bit of the register high, flags untouched.
// - Bit test reading one lets the next instruction run; one cycle, no flags.
// - Bit test reading zero turns the next instruction into a no-operation.
// - Bit set or clear on the port register starts from the pin levels.
//
// Added by the designer: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
`include "aabe_cfg.svh"

module aabe_exec (
  input  wire logic                ref_clk,
  input  wire logic                arst_n,
  input  wire logic                instr_valid,
  input  wire aabe_pkg::aabe_op_t  instr_op,
  input  wire logic [6:0]          instr_file,
  input  wire logic [2:0]          instr_bit,
  input  wire logic [7:0]          instr_imm,
  input  wire logic                instr_dest,
  input  wire logic [7:0]          port_pins,
  output logic      [7:0]          port_latch,
  output logic                     skip_active,
  output logic      [7:0]          acc_out,
  output logic      [2:0]          status_out,
  input  wire logic [7:0]          bus_addr,
  input  wire logic [7:0]          bus_wdata,
  input  wire logic                bus_wr,
  input  wire logic                bus_rd,
  output logic      [7:0]          bus_rdata
);

  aabe_pkg::aabe_state_t st;
  aabe_pkg::aabe_state_t next_st;
  logic [7:0]            f_val;
  logic [7:0]            bus_val;
  logic [7:0]            stat_byte;
  logic                  exec;
  logic                  bit_one;

  aabe_alu_if alu_bus ();

  aabe_alu u_alu (
    .u (alu_bus)
  );

  // ========================================================================
  // Operand fetch
  // ========================================================================
  // The port register reads the pins, not its latch, so a read-modify-write
  // never copies a stale latch bit onto a pin that someone else pulls.
  always_comb
  begin
    if (instr_file == `AABE_PORT_FILE)
      f_val = port_pins;
    else
      f_val = st.files[instr_file];
  end

  assign exec      = instr_valid && (st.phase == aabe_pkg::PH_RUN);
  assign bit_one   = |(f_val & aabe_pkg::aabe_bit_mask(instr_bit));
  assign stat_byte = {`AABE_STAT_PAD, st.flag_zero, st.nibble_overflow_bit, st.flag_carry};

  always_comb
  begin
    if (bus_addr[`AABE_FILE_SEL_BIT] == 1'b0)
    begin
      if (bus_addr[`AABE_FILE_SEL_BIT-1:0] == `AABE_PORT_FILE)
        bus_val = port_pins;
      else
        bus_val = st.files[bus_addr[`AABE_FILE_SEL_BIT-1:0]];
    end
    else if (bus_addr == `AABE_ACC_ADDR)
      bus_val = st.acc;
    else if (bus_addr == `AABE_STAT_ADDR)
      bus_val = stat_byte;
    else
      bus_val = `AABE_BYTE_RST;
  end

  // ========================================================================
  // Operand steering into the arithmetic unit
  // ========================================================================
  always_comb
  begin
    alu_bus.a       = st.acc;
    alu_bus.b       = f_val;
    alu_bus.bit_idx = instr_bit;
    alu_bus.kind    = aabe_pkg::ALU_ADD;
    case (instr_op)
      aabe_pkg::immediate_sum_op:
      begin
        alu_bus.b = instr_imm;
      end
      aabe_pkg::immediate_mask_op:
      begin
        alu_bus.b    = instr_imm;
        alu_bus.kind = aabe_pkg::ALU_AND;
      end
      aabe_pkg::register_mask_op:
      begin
        alu_bus.kind = aabe_pkg::ALU_AND;
      end
      aabe_pkg::single_position_clear_op:
      begin
        alu_bus.a    = f_val;
        alu_bus.kind = aabe_pkg::ALU_CLR;
      end
      aabe_pkg::single_position_set_op:
      begin
        alu_bus.a    = f_val;
        alu_bus.kind = aabe_pkg::ALU_SET;
      end
      default:
      begin
        alu_bus.kind = aabe_pkg::ALU_ADD;
      end
    endcase
  end

  // ========================================================================
  // Next state
  // ========================================================================
  // Bus writes are applied first so that an instruction in the same cycle
  // overrides them; software should not race the core on one location.
  always_comb
  begin
    next_st       = st;
    next_st.rdata = bus_rd ? bus_val : `AABE_BYTE_RST;
    if (bus_wr)
    begin
      if (bus_addr[`AABE_FILE_SEL_BIT] == 1'b0)
        next_st.files[bus_addr[`AABE_FILE_SEL_BIT-1:0]] = bus_wdata;
      else if (bus_addr == `AABE_ACC_ADDR)
        next_st.acc = bus_wdata;
      else if (bus_addr == `AABE_STAT_ADDR)
      begin
        next_st.flag_carry          = bus_wdata[`AABE_C_BIT];
        next_st.nibble_overflow_bit = bus_wdata[`AABE_DC_BIT];
        next_st.flag_zero           = bus_wdata[`AABE_Z_BIT];
      end
    end
    case (st.phase)
      aabe_pkg::PH_DISCARD:
      begin
        if (instr_valid)
          next_st.phase = aabe_pkg::PH_RUN;
      end
      aabe_pkg::PH_RUN:
      begin
        if (instr_valid)
        begin
          case (instr_op)
            aabe_pkg::immediate_sum_op, aabe_pkg::register_sum_op:
            begin
              if (instr_op == aabe_pkg::register_sum_op && instr_dest == `AABE_DEST_FILE)
                next_st.files[instr_file] = alu_bus.y;
              else
                next_st.acc = alu_bus.y;
              next_st.flag_carry          = alu_bus.carry;
              next_st.nibble_overflow_bit = alu_bus.nib_carry;
              next_st.flag_zero           = alu_bus.zero;
            end
            aabe_pkg::immediate_mask_op, aabe_pkg::register_mask_op:
            begin
              if (instr_op == aabe_pkg::register_mask_op && instr_dest == `AABE_DEST_FILE)
                next_st.files[instr_file] = alu_bus.y;
              else
                next_st.acc = alu_bus.y;
              next_st.flag_zero = alu_bus.zero;
            end
            aabe_pkg::single_position_clear_op, aabe_pkg::single_position_set_op:
            begin
              next_st.files[instr_file] = alu_bus.y;
            end
            aabe_pkg::test_then_skip_if_zero_op:
            begin
              if (!bit_one)
                next_st.phase = aabe_pkg::PH_DISCARD;
            end
            default:
            begin
              next_st.phase = aabe_pkg::PH_RUN;
            end
          endcase
        end
      end
      default:
      begin
        next_st.phase = aabe_pkg::PH_RUN;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      st <= '0;
    else
      st <= next_st;
  end

  assign port_latch  = st.files[`AABE_PORT_FILE];
  assign skip_active = (st.phase == aabe_pkg::PH_DISCARD);
  assign acc_out     = st.acc;
  assign status_out  = stat_byte[`AABE_Z_BIT:`AABE_C_BIT];
  assign bus_rdata   = st.rdata;

  // ========================================================================
  // Checks
  // ========================================================================
  logic [8:0] chk_sum9;
  logic [4:0] chk_nib5;
  logic [7:0] chk_mask;

  assign chk_sum9 = {1'b0, st.acc} + {1'b0, instr_imm};
  assign chk_nib5 = {1'b0, st.acc[`AABE_NIB_MSB:0]} + {1'b0, instr_imm[`AABE_NIB_MSB:0]};
  assign chk_mask = aabe_pkg::aabe_bit_mask(instr_bit);

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!arst_n);

  imm_sum_a: assert property (
    exec && instr_op == aabe_pkg::immediate_sum_op && !bus_wr
    |=> acc_out == $past(chk_sum9[7:0]))
    else $error("immediate add result wrong");

  reg_sum_a: assert property (
    exec && instr_op == aabe_pkg::register_sum_op && instr_dest == `AABE_DEST_ACC && !bus_wr
    |=> acc_out == 8'($past(st.acc) + $past(f_val)))
    else $error("register add result wrong");

  dest_file_a: assert property (
    exec && instr_dest == `AABE_DEST_FILE && !bus_wr
    && (instr_op == aabe_pkg::register_sum_op || instr_op == aabe_pkg::register_mask_op)
    |=> $stable(acc_out))
    else $error("file destination disturbed accumulator");

  imm_mask_a: assert property (
    exec && instr_op == aabe_pkg::immediate_mask_op && !bus_wr
    |=> acc_out == ($past(st.acc) & $past(instr_imm)) && $stable(status_out[1:0]))
    else $error("immediate AND wrong or extra flags changed");

  reg_mask_a: assert property (
    exec && instr_op == aabe_pkg::register_mask_op && instr_dest == `AABE_DEST_ACC && !bus_wr
    |=> acc_out == ($past(st.acc) & $past(f_val)) && $stable(status_out[1:0]))
    else $error("register AND wrong or extra flags changed");

  bit_clear_a: assert property (
    exec && instr_op == aabe_pkg::single_position_clear_op && !bus_wr
    |=> $stable(status_out) && $stable(acc_out))
    else $error("bit clear touched flags");

  bit_set_port_a: assert property (
    exec && instr_op == aabe_pkg::single_position_set_op && instr_file == `AABE_PORT_FILE && !bus_wr
    |=> port_latch == ($past(port_pins) | $past(chk_mask)) && $stable(status_out))
    else $error("bit set on port wrong");

  clear_port_a: assert property (
    exec && instr_op == aabe_pkg::single_position_clear_op && instr_file == `AABE_PORT_FILE
    |=> port_latch == ($past(port_pins) & ~$past(chk_mask)))
    else $error("bit clear on port ignored pins");

  test_one_a: assert property (
    exec && instr_op == aabe_pkg::test_then_skip_if_zero_op && bit_one && !bus_wr
    |=> !skip_active && $stable(status_out) && $stable(acc_out))
    else $error("test of set bit did not run one cycle");

  test_zero_a: assert property (
    exec && instr_op == aabe_pkg::test_then_skip_if_zero_op && !bit_one
    |=> skip_active)
    else $error("test of clear bit did not skip");

  discard_nop_a: assert property (
    skip_active && instr_valid && !bus_wr
    |=> !skip_active && $stable(acc_out) && $stable(status_out) && $stable(port_latch))
    else $error("discarded instruction had an effect");

  carry_flags_a: assert property (
    exec && instr_op == aabe_pkg::immediate_sum_op && !bus_wr
    |=> status_out[`AABE_C_BIT] == $past(chk_sum9[8])
    && status_out[`AABE_DC_BIT] == $past(chk_nib5[4]))
    else $error("carry or nibble carry wrong");

  zero_flag_a: assert property (
    exec && !bus_wr
    && (instr_op == aabe_pkg::immediate_sum_op || instr_op == aabe_pkg::immediate_mask_op)
    |=> status_out[`AABE_Z_BIT] == (acc_out == `AABE_BYTE_RST))
    else $error("zero flag not updated in the same cycle");

endmodule : aabe_exec

`default_nettype wire

// ---- sim/tb_aabe_exec.sv ----
// Purpose: Self-checking bench for the add, mask and bit-operation datapath.
// Assumes: Inputs change by non-blocking assignment at the rising edge.
// Notes:   Expected values are worked out here, never read back from the design.
`timescale 1ns/1ps
`default_nettype none
`include "aabe_cfg.svh"

module tb_aabe_exec;
  logic                ref_clk;
  logic                arst_n;
  logic                instr_valid;
  aabe_pkg::aabe_op_t  instr_op;
  logic [6:0]          instr_file;
  logic [2:0]          instr_bit;
  logic [7:0]          instr_imm;
  logic                instr_dest;
  logic [7:0]          port_pins;
  logic [7:0]          port_latch;
  logic                skip_active;
  logic [7:0]          acc_out;
  logic [2:0]          status_out;
  logic [7:0]          bus_addr;
  logic [7:0]          bus_wdata;
  logic                bus_wr;
  logic                bus_rd;
  logic [7:0]          bus_rdata;
  int                  fail_count;
  int                  tests_run;
  int                  cycles;

  aabe_exec i_aabe_exec (.ref_clk(ref_clk), .arst_n(arst_n), .instr_valid(instr_valid), .instr_op(instr_op),
    .instr_file(instr_file), .instr_bit(instr_bit), .instr_imm(instr_imm), .instr_dest(instr_dest),
    .port_pins(port_pins), .port_latch(port_latch), .skip_active(skip_active), .acc_out(acc_out),
    .status_out(status_out), .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd),
    .bus_rdata(bus_rdata));

  // ==========================================================================
  // Clock, timeout and shared tasks
  // ==========================================================================
  initial
  begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  // The ceiling is over ten times the roughly 160 cycles the scenarios need.
  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == 2000)
    begin
      fail_count++;
      give_verdict();
    end
  end

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : give_verdict

  task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
    tests_run++;
    if (got !== exp)
    begin
      fail_count++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask : check

  task automatic bus_write(input logic [7:0] addr, input logic [7:0] data);
    @(posedge ref_clk);
    bus_wr    <= 1'b1;
    bus_addr  <= addr;
    bus_wdata <= data;
    @(posedge ref_clk);
    bus_wr <= 1'b0;
  endtask : bus_write

  // Read data stand only in the cycle after the strobe, so sample right there.
  task automatic bus_read(input logic [7:0] addr, input logic [7:0] exp, input string name);
    @(posedge ref_clk);
    bus_rd   <= 1'b1;
    bus_addr <= addr;
    @(posedge ref_clk);
    bus_rd <= 1'b0;
    #1;
    check(name, exp, bus_rdata);
  endtask : bus_read

  task automatic drive(input aabe_pkg::aabe_op_t op, input logic [6:0] f, input logic [2:0] b,
                       input logic [7:0] k, input logic d);
    instr_valid <= 1'b1;
    instr_op    <= op;
    instr_file  <= f;
    instr_bit   <= b;
    instr_imm   <= k;
    instr_dest  <= d;
  endtask : drive

  task automatic issue(input aabe_pkg::aabe_op_t op, input logic [6:0] f, input logic [2:0] b,
                       input logic [7:0] k, input logic d);
    @(posedge ref_clk);
    drive(op, f, b, k, d);
    @(posedge ref_clk);
    instr_valid <= 1'b0;
    #1;
  endtask : issue

  task automatic check_core(input logic [7:0] acc, input logic [2:0] st);
    check("acc", acc, acc_out);
    check("status", {5'h00, st}, {5'h00, status_out});
  endtask : check_core

  // ==========================================================================
  // Scenarios
  // ==========================================================================
  task automatic sc_add();
    bus_write(8'h80, 8'hFF);
    issue(aabe_pkg::immediate_sum_op, 7'h00, 3'h0, 8'h01, 1'b0);
    check_core(8'h00, 3'b111);
    issue(aabe_pkg::immediate_sum_op, 7'h00, 3'h0, 8'h08, 1'b0);
    issue(aabe_pkg::immediate_sum_op, 7'h00, 3'h0, 8'h08, 1'b0);
    check_core(8'h10, 3'b010);
    bus_write(8'h05, 8'h80);
    bus_write(8'h80, 8'h80);
    issue(aabe_pkg::register_sum_op, 7'h05, 3'h0, 8'h00, 1'b0);
    check_core(8'h00, 3'b101);
    bus_write(8'h80, 8'h12);
    bus_write(8'h7F, 8'h34);
    issue(aabe_pkg::register_sum_op, 7'h7F, 3'h0, 8'h00, 1'b1);
    check_core(8'h12, 3'b000);
    bus_read(8'h7F, 8'h46, "file_7f");
    bus_read(8'h81, 8'h00, "status_reg");
  endtask : sc_add

  task automatic sc_mask();
    bus_write(8'h80, 8'hFF);
    issue(aabe_pkg::immediate_sum_op, 7'h00, 3'h0, 8'h01, 1'b0);
    bus_write(8'h80, 8'hF0);
    issue(aabe_pkg::immediate_mask_op, 7'h00, 3'h0, 8'h0F, 1'b0);
    check_core(8'h00, 3'b111);
    bus_write(8'h80, 8'h3C);
    issue(aabe_pkg::immediate_mask_op, 7'h00, 3'h0, 8'h0C, 1'b0);
    check_core(8'h0C, 3'b011);
    bus_write(8'h11, 8'h0F);
    issue(aabe_pkg::register_mask_op, 7'h11, 3'h0, 8'h00, 1'b1);
    check_core(8'h0C, 3'b011);
    bus_read(8'h11, 8'h0C, "file_11");
    issue(aabe_pkg::register_mask_op, 7'h12, 3'h0, 8'h00, 1'b0);
    check_core(8'h00, 3'b111);
  endtask : sc_mask

  // Every bit index is set, then cleared, while the flags must not move.
  task automatic sc_bits();
    for (int i = 0; i < 8; i++)
    begin
      issue(aabe_pkg::single_position_set_op, 7'h10, 3'(i), 8'h00, 1'b0);
      bus_read(8'h10, 8'((16'h0002 << i) - 16'h0001), "set_bits");
      check_core(8'h00, 3'b111);
    end
    for (int i = 0; i < 8; i++)
    begin
      issue(aabe_pkg::single_position_clear_op, 7'h10, 3'(i), 8'h00, 1'b0);
      bus_read(8'h10, 8'(16'h00FF << (i + 1)), "clear_bits");
      check_core(8'h00, 3'b111);
    end
  endtask : sc_bits

  task automatic sc_port();
    @(posedge ref_clk);
    port_pins <= 8'hA5;
    bus_write(8'h06, 8'h00);
    #1;
    check("latch", 8'h00, port_latch);
    issue(aabe_pkg::single_position_set_op, 7'h06, 3'h1, 8'h00, 1'b0);
    check("latch", 8'hA7, port_latch);
    @(posedge ref_clk);
    port_pins <= 8'h5A;
    issue(aabe_pkg::single_position_clear_op, 7'h06, 3'h1, 8'h00, 1'b0);
    check("latch", 8'h58, port_latch);
    bus_read(8'h06, 8'h5A, "pins");
  endtask : sc_port

  task automatic sc_skip();
    bus_write(8'h20, 8'h01);
    @(posedge ref_clk);
    drive(aabe_pkg::test_then_skip_if_zero_op, 7'h20, 3'h0, 8'h00, 1'b0);
    @(posedge ref_clk);
    drive(aabe_pkg::immediate_sum_op, 7'h00, 3'h0, 8'h05, 1'b0);
    #1;
    check("skip", 8'h00, {7'h00, skip_active});
    check_core(8'h00, 3'b111);
    @(posedge ref_clk);
    drive(aabe_pkg::test_then_skip_if_zero_op, 7'h20, 3'h1, 8'h00, 1'b0);
    #1;
    check_core(8'h05, 3'b000);
    @(posedge ref_clk);
    instr_valid <= 1'b0;
    #1;
    check("skip", 8'h01, {7'h00, skip_active});
    // An idle cycle must not use up the pending skip.
    @(posedge ref_clk);
    drive(aabe_pkg::immediate_sum_op, 7'h00, 3'h0, 8'h05, 1'b0);
    #1;
    check("skip", 8'h01, {7'h00, skip_active});
    @(posedge ref_clk);
    instr_valid <= 1'b0;
    #1;
    check("skip", 8'h00, {7'h00, skip_active});
    check_core(8'h05, 3'b000);
    issue(aabe_pkg::immediate_sum_op, 7'h00, 3'h0, 8'h01, 1'b0);
    check_core(8'h06, 3'b000);
  endtask : sc_skip

  // An unmapped write is dropped, and a reset in mid-run clears without a clock.
  task automatic sc_misc();
    bus_write(8'h90, 8'h55);
    bus_read(8'h90, 8'h00, "unmapped");
    bus_write(8'h81, 8'h05);
    bus_read(8'h81, 8'h05, "status_wr");
    bus_read(8'h80, 8'h06, "acc_reg");
    @(posedge ref_clk);
    #1;
    check("rdata_idle", 8'h00, bus_rdata);
    // An instruction and a bus write to the accumulator in one cycle: the instruction wins.
    @(posedge ref_clk);
    bus_wr    <= 1'b1;
    bus_addr  <= 8'h80;
    bus_wdata <= 8'hAA;
    drive(aabe_pkg::immediate_sum_op, 7'h00, 3'h0, 8'h01, 1'b0);
    @(posedge ref_clk);
    bus_wr      <= 1'b0;
    instr_valid <= 1'b0;
    #1;
    check_core(8'h07, 3'b000);
    @(posedge ref_clk);
    arst_n <= 1'b0;
    #1;
    check_core(8'h00, 3'b000);
    check("latch", 8'h00, port_latch);
    repeat (3) @(posedge ref_clk);
    arst_n <= 1'b1;
    bus_read(8'h20, 8'h00, "file_reset");
  endtask : sc_misc

  initial
  begin
    arst_n      = 1'b0;
    instr_valid = 1'b0;
    instr_op    = aabe_pkg::op_none;
    instr_file  = 7'h00;
    instr_bit   = 3'h0;
    instr_imm   = 8'h00;
    instr_dest  = 1'b0;
    port_pins   = 8'h00;
    bus_addr    = 8'h00;
    bus_wdata   = 8'h00;
    bus_wr      = 1'b0;
    bus_rd      = 1'b0;
    fail_count  = 0;
    tests_run   = 0;
    cycles      = 0;
    repeat (12) @(posedge ref_clk);
    arst_n <= 1'b1;
    #1;
    check_core(8'h00, 3'b000);
    check("skip", 8'h00, {7'h00, skip_active});
    sc_add();
    sc_mask();
    sc_bits();
    sc_port();
    sc_skip();
    sc_misc();
    give_verdict();
  end
endmodule : tb_aabe_exec

`default_nettype wire
